/* hdl/ugcs_pkg.sv */
/*
 * Shared constants for the upper port configuration and port state block:
 * register offsets, reset values, mode field layout and pin mode codes.
 * Assumes an 8-bit register port with byte offsets as printed.
 */
package ugcs_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PIN_COUNT   = 8;
  localparam int unsigned MODE_W      = 2;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] OFF_PORT_OUTPUT_LEVEL = 8'h01;
  localparam logic [7:0] OFF_UPPER_PIN_MODE    = 8'h07;
  localparam logic [7:0] RST_PORT_OUTPUT_LEVEL = 8'h00;
  localparam logic [7:0] RST_UPPER_PIN_MODE    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ         = 8'h00;

  // ****************************************************************
  // Mode field positions inside the upper mode register
  // ****************************************************************
  localparam int unsigned PIN7_MODE_LSB = 6;
  localparam int unsigned PIN6_MODE_LSB = 4;
  localparam int unsigned PIN5_MODE_LSB = 2;
  localparam int unsigned PIN4_MODE_LSB = 0;
  localparam int unsigned UPPER_PIN_BASE = 4;

  // ****************************************************************
  // Pin mode codes
  // ****************************************************************
  typedef enum logic [1:0] {
    UGCS_MODE_OPEN_DRAIN = 2'h0,
    UGCS_MODE_INPUT      = 2'h1,
    UGCS_MODE_PUSH_PULL  = 2'h2,
    UGCS_MODE_INPUT_ALT  = 2'h3
  } ugcs_mode_t;

endpackage : ugcs_pkg

/* hdl/ugcs_pin_if.sv */
/*
 * Carrier between the register core, the pin drivers and the pin sampler.
 * Assumes all parties share one clock and the synchronised reset.
 */
`timescale 1ns/1ps

interface ugcs_pin_if;

  logic [7:0] upper_pin_mode;
  logic [7:0] lower_pin_mode;
  logic [7:0] port_output_level;
  logic [7:0] port_pin_levels;

  // Register core: owns the mode and level registers, reads pin levels.
  modport core (
    output upper_pin_mode,
    output lower_pin_mode,
    output port_output_level,
    input  port_pin_levels
  );

  // Pin drivers: turn modes and levels into drive and enable.
  modport drive (
    input  upper_pin_mode,
    input  lower_pin_mode,
    input  port_output_level
  );

  // Pin sampler: returns the levels seen on the pins.
  modport sample (
    output port_pin_levels
  );

endinterface : ugcs_pin_if

/* hdl/ugcs_pin_drive.sv */
/*
 * Per-pin output stage: decodes each two-bit mode and drives pin level and
 * active-low output enable from flip-flops.
 * Assumes the caller resolves the pin wire from the enable.
 */
`timescale 1ns/1ps

module ugcs_pin_drive (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ugcs_pin_if.drive       pins,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe_n
);

  // ****************************************************************
  // Per-pin mode decode
  // ****************************************************************
  logic [15:0] all_modes;

  assign all_modes = {pins.upper_pin_mode, pins.lower_pin_mode};

  for (genvar i = 0; i < 8; i++) begin : g_pin
    ugcs_pkg::ugcs_mode_t mode;
    logic                 next_out;
    logic                 next_oe_n;

    assign mode = ugcs_pkg::ugcs_mode_t'(all_modes[2*i +: 2]);

    // Open drain pulls low for a 0 and releases for a 1; input modes never drive.
    always_comb begin
      next_out  = 1'b0;
      next_oe_n = 1'b1;
      unique case (mode)
        ugcs_pkg::UGCS_MODE_OPEN_DRAIN: begin
          next_out  = 1'b0;
          next_oe_n = pins.port_output_level[i];
        end
        ugcs_pkg::UGCS_MODE_PUSH_PULL: begin
          next_out  = pins.port_output_level[i];
          next_oe_n = 1'b0;
        end
        ugcs_pkg::UGCS_MODE_INPUT,
        ugcs_pkg::UGCS_MODE_INPUT_ALT: begin
          next_out  = 1'b0;
          next_oe_n = 1'b1;
        end
      endcase
    end

    // Registered so the pads see no decode glitches; reset leaves pins undriven.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_out[i]  <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end else begin
        pin_out[i]  <= next_out;
        pin_oe_n[i] <= next_oe_n;
      end
    end
  end

endmodule : ugcs_pin_drive

/* hdl/ugcs_pin_sample.sv */
/*
 * Pin level sampler: registers the levels present on the eight port pins.
 * Assumes pin inputs are synchronous to the clock.
 */
`timescale 1ns/1ps

module ugcs_pin_sample (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] pin_in,
  ugcs_pin_if.sample      pins
);

  logic [7:0] next_levels;

  // One register stage; the level read back is the pin, not the written value.
  always_comb begin
    next_levels = pin_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.port_pin_levels <= 8'h00;
    end else begin
      pins.port_pin_levels <= next_levels;
    end
  end

endmodule : ugcs_pin_sample

/* hdl/ugcs_top.sv */
/*
 * Upper port configuration and port state block: register port, mode and
 * level registers, pin drivers and pin sampler.
 * Assumes one 25 MHz clock, pin inputs synchronous to it, and an external
 * owner of the lower pin mode configuration driving LOWER_PIN_MODE.
 */
// The strobed register port is this design's own decision.
// What this block does
// - Pin 7 mode field sits in upper mode register bits 7 and 6.
// - Pin 6 mode field sits in upper mode register bits 5 and 4.
// - Pin 5 mode field sits in upper mode register bits 3 and 2.
// - Pin 4 mode field sits in upper mode register bits 1 and 0.
// - Mode 00 open drain, 01 input, 10 push-pull, 11 input.
// - Writing the port state register sets each pin's output level, bit per pin.
// - Reading the port state register returns sampled pin levels, not written values.
`timescale 1ns/1ps

module ugcs_top (
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [7:0] LOWER_PIN_MODE,
  input  wire logic [7:0] PIN_IN,
  output logic      [7:0] PIN_OUT,
  output logic      [7:0] PIN_OE_N
);

  // ****************************************************************
  // Reset release
  // ****************************************************************

  logic rst_meta_n;
  logic rst_n;

  // Reset asserts at once but leaves on the clock, so no flop sees a partial release.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************

  ugcs_pin_if pins ();

  logic [7:0] upper_pin_mode;
  logic [7:0] port_output_level;
  logic [7:0] read_data;
  logic [7:0] next_upper_pin_mode;
  logic [7:0] next_port_output_level;
  logic [7:0] next_read_data;
  logic       hit_level;
  logic       hit_mode;

  // Offsets decode exactly; there are no aliases, which keeps every other offset reading zero.
  assign hit_level = (ADDR == ugcs_pkg::OFF_PORT_OUTPUT_LEVEL);
  assign hit_mode  = (ADDR == ugcs_pkg::OFF_UPPER_PIN_MODE);

  // Writes to unmapped offsets are dropped; every field is stored whole.
  always_comb begin
    next_upper_pin_mode    = upper_pin_mode;
    next_port_output_level = port_output_level;
    if (WR && hit_mode) begin
      next_upper_pin_mode[ugcs_pkg::PIN7_MODE_LSB +: 2] = WDATA[ugcs_pkg::PIN7_MODE_LSB +: 2];
      next_upper_pin_mode[ugcs_pkg::PIN6_MODE_LSB +: 2] = WDATA[ugcs_pkg::PIN6_MODE_LSB +: 2];
      next_upper_pin_mode[ugcs_pkg::PIN5_MODE_LSB +: 2] = WDATA[ugcs_pkg::PIN5_MODE_LSB +: 2];
      next_upper_pin_mode[ugcs_pkg::PIN4_MODE_LSB +: 2] = WDATA[ugcs_pkg::PIN4_MODE_LSB +: 2];
    end
    if (WR && hit_level) begin
      next_port_output_level = WDATA;
    end
  end

  // Read data is captured on the strobe and held only for the following cycle.
  always_comb begin
    next_read_data = ugcs_pkg::UNMAPPED_READ;
    if (RD && hit_level) begin
      next_read_data = pins.port_pin_levels;
    end else if (RD && hit_mode) begin
      next_read_data = upper_pin_mode;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      upper_pin_mode    <= ugcs_pkg::RST_UPPER_PIN_MODE;
      port_output_level <= ugcs_pkg::RST_PORT_OUTPUT_LEVEL;
      read_data         <= ugcs_pkg::UNMAPPED_READ;
    end else begin
      upper_pin_mode    <= next_upper_pin_mode;
      port_output_level <= next_port_output_level;
      read_data         <= next_read_data;
    end
  end

  // The carrier hands the stored registers to the pad stage; lower modes come straight from the port.
  assign RDATA                  = read_data;
  assign pins.upper_pin_mode    = upper_pin_mode;
  assign pins.lower_pin_mode    = LOWER_PIN_MODE;
  assign pins.port_output_level = port_output_level;

  // ****************************************************************
  // Pin stages
  // ****************************************************************

  ugcs_pin_drive u_drive (
    .clk      (CLOCK),
    .rst_n    (rst_n),
    .pins     (pins.drive),
    .pin_out  (PIN_OUT),
    .pin_oe_n (PIN_OE_N)
  );

  ugcs_pin_sample u_sample (
    .clk    (CLOCK),
    .rst_n  (rst_n),
    .pin_in (PIN_IN),
    .pins   (pins.sample)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************

  // All checks run on the system clock and stay quiet while the synchronised reset is low.
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n);

  logic       wr_mode;
  logic       wr_level;
  logic       rd_level;
  logic       rd_other;
  logic [1:0] wd_pin7;
  logic [1:0] wd_pin6;
  logic [1:0] wd_pin5;
  logic [1:0] wd_pin4;
  // Mode fields by pin (7 to 4 stored, 3 and 0 from LOWER_PIN_MODE), so that the drive checks read like the mode table.
  logic [1:0] mode_pin7;
  logic [1:0] mode_pin6;
  logic [1:0] mode_pin5;
  logic [1:0] mode_pin4;
  logic [1:0] mode_pin3;
  logic [1:0] mode_pin0;

  assign wr_mode  = WR && hit_mode;
  assign wr_level = WR && hit_level;
  assign rd_level = RD && hit_level;
  assign rd_other = RD && !hit_level && !hit_mode;
  assign wd_pin7  = WDATA[7:6];
  assign wd_pin6  = WDATA[5:4];
  assign wd_pin5  = WDATA[3:2];
  assign wd_pin4  = WDATA[1:0];
  assign mode_pin7 = upper_pin_mode[ugcs_pkg::PIN7_MODE_LSB +: 2];
  assign mode_pin6 = upper_pin_mode[ugcs_pkg::PIN6_MODE_LSB +: 2];
  assign mode_pin5 = upper_pin_mode[ugcs_pkg::PIN5_MODE_LSB +: 2];
  assign mode_pin4 = upper_pin_mode[ugcs_pkg::PIN4_MODE_LSB +: 2];
  assign mode_pin3 = LOWER_PIN_MODE[7:6];
  assign mode_pin0 = LOWER_PIN_MODE[1:0];

  sequence s_mode_write;
    wr_mode;
  endsequence

  sequence s_level_read;
    rd_level;
  endsequence

  property p_pin7_field;
    s_mode_write |=> upper_pin_mode[7:6] == $past(wd_pin7);
  endproperty
  a_pin7_field: assert property (p_pin7_field) else $error("pin 7 mode field not stored in bits 7:6");

  property p_pin6_field;
    s_mode_write |=> upper_pin_mode[5:4] == $past(wd_pin6);
  endproperty
  a_pin6_field: assert property (p_pin6_field) else $error("pin 6 mode field not stored in bits 5:4");

  property p_pin5_field;
    s_mode_write |=> upper_pin_mode[3:2] == $past(wd_pin5);
  endproperty
  a_pin5_field: assert property (p_pin5_field) else $error("pin 5 mode field not stored in bits 3:2");

  property p_pin4_field;
    s_mode_write |=> upper_pin_mode[1:0] == $past(wd_pin4);
  endproperty
  a_pin4_field: assert property (p_pin4_field) else $error("pin 4 mode field not stored in bits 1:0");

  // A pin 7 push-pull setting reaches the pad two edges after the write.
  property p_pin7_push_pull;
    (wr_mode && wd_pin7 == 2'h2) ##1 !wr_mode && !wr_level |=> !PIN_OE_N[7] && PIN_OUT[7] == port_output_level[7];
  endproperty
  a_pin7_push_pull: assert property (p_pin7_push_pull) else $error("pin 7 not push-pull after mode 10");

  // Input codes release the pad; open drain releases only for a high level; push-pull drives the level.
  // The pad stage sits one flop behind the registers, so the expectation uses last cycle's values.
  property p_upper_drive;
    $past(rst_n) |-> PIN_OE_N[7] == ($past(mode_pin7) == 2'h1 || $past(mode_pin7) == 2'h3 ||
                                     ($past(mode_pin7) == 2'h0 && $past(port_output_level[7]))) &&
                     PIN_OUT[7] == ($past(mode_pin7) == 2'h2 && $past(port_output_level[7]));
  endproperty
  a_upper_drive: assert property (p_upper_drive) else $error("pin 7 enable disagrees with its mode");

  // Pin 6 follows only its own field and its own level bit.
  property p_pin6_drive;
    $past(rst_n) |-> PIN_OE_N[6] == ($past(mode_pin6) == 2'h1 || $past(mode_pin6) == 2'h3 ||
                                     ($past(mode_pin6) == 2'h0 && $past(port_output_level[6]))) &&
                     PIN_OUT[6] == ($past(mode_pin6) == 2'h2 && $past(port_output_level[6]));
  endproperty
  a_pin6_drive: assert property (p_pin6_drive) else $error("pin 6 drive wrong for its mode");

  // Pin 5 follows only its own field and its own level bit.
  property p_pin5_drive;
    $past(rst_n) |-> PIN_OE_N[5] == ($past(mode_pin5) == 2'h1 || $past(mode_pin5) == 2'h3 ||
                                     ($past(mode_pin5) == 2'h0 && $past(port_output_level[5]))) &&
                     PIN_OUT[5] == ($past(mode_pin5) == 2'h2 && $past(port_output_level[5]));
  endproperty
  a_pin5_drive: assert property (p_pin5_drive) else $error("pin 5 drive wrong for its mode");

  // Pin 4 follows only its own field and its own level bit.
  property p_pin4_drive;
    $past(rst_n) |-> PIN_OE_N[4] == ($past(mode_pin4) == 2'h1 || $past(mode_pin4) == 2'h3 ||
                                     ($past(mode_pin4) == 2'h0 && $past(port_output_level[4]))) &&
                     PIN_OUT[4] == ($past(mode_pin4) == 2'h2 && $past(port_output_level[4]));
  endproperty
  a_pin4_drive: assert property (p_pin4_drive) else $error("pin 4 drive wrong for its mode");

  // Lower pins decode the same codes from the outside mode word; pin 3 is the top of it.
  property p_pin3_drive;
    $past(rst_n) |-> PIN_OE_N[3] == ($past(mode_pin3) == 2'h1 || $past(mode_pin3) == 2'h3 ||
                                     ($past(mode_pin3) == 2'h0 && $past(port_output_level[3]))) &&
                     PIN_OUT[3] == ($past(mode_pin3) == 2'h2 && $past(port_output_level[3]));
  endproperty
  a_pin3_drive: assert property (p_pin3_drive) else $error("pin 3 drive wrong for its mode");

  // Pin 0 takes level bit 0, the bottom of the port state register.
  property p_pin0_drive;
    $past(rst_n) |-> PIN_OE_N[0] == ($past(mode_pin0) == 2'h1 || $past(mode_pin0) == 2'h3 ||
                                     ($past(mode_pin0) == 2'h0 && $past(port_output_level[0]))) &&
                     PIN_OUT[0] == ($past(mode_pin0) == 2'h2 && $past(port_output_level[0]));
  endproperty
  a_pin0_drive: assert property (p_pin0_drive) else $error("pin 0 drive wrong for its mode");

  property p_open_drain_low;
    (upper_pin_mode[5:4] == 2'h0) && $stable(upper_pin_mode) |-> !PIN_OUT[6];
  endproperty
  a_open_drain_low: assert property (p_open_drain_low) else $error("open drain pin 6 drives a high level");

  property p_level_write;
    wr_level |=> port_output_level == $past(WDATA);
  endproperty
  a_level_write: assert property (p_level_write) else $error("port state write not stored");

  property p_level_read;
    s_level_read |=> RDATA == $past(pins.port_pin_levels);
  endproperty
  a_level_read: assert property (p_level_read) else $error("port state read not the sampled pins");

  property p_level_read_source;
    ##1 s_level_read |=> RDATA == $past(PIN_IN, 2);
  endproperty
  a_level_read_source: assert property (p_level_read_source) else $error("port state read not the pins");

  property p_unmapped_read;
    rd_other |=> RDATA == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Reading the mode register returns the stored fields in their own positions.
  property p_mode_read;
    RD && hit_mode |=> RDATA == $past(upper_pin_mode);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode register read wrong");

  // Only a write to its own offset may change the mode register.
  property p_mode_hold;
    !wr_mode |=> $stable(upper_pin_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode register changed without a write");

  // Only a write to its own offset may change the output levels.
  property p_level_hold;
    !wr_level |=> $stable(port_output_level);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("output levels changed without a write");

  // Read data stand for one cycle only; a cycle without a read leaves zero behind it.
  property p_rdata_idle;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero after an idle cycle");

  property p_reset_values;
    $rose(rst_n) |-> upper_pin_mode == 8'h00 && port_output_level == 8'h00;
  endproperty
  a_reset_values: assert property (@(posedge CLOCK) p_reset_values) else $error("reset values wrong");

  property p_reset_drive;
    $rose(rst_n) && !wr_mode && !wr_level ##1 !wr_mode && !wr_level |=> PIN_OE_N[7:4] == 4'h0 && PIN_OUT[7:4] == 4'h0;
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("upper pins not driven low after reset");

endmodule : ugcs_top

/* tb/testbench.sv */
/*
 * Self-checking bench for the upper port mode and port state block.
 * Assumes the design files are compiled first and the pins are synchronous.
 */
`timescale 1ns/1ps

module testbench;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       clock;
  logic       nrst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] lower_mode;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] mode_q;
  logic [7:0] lvl_q;
  logic [7:0] got;
  int         mismatches;
  int         checks;
  int         seed;

  ugcs_top dut (
    .CLOCK          (clock),
    .NRST           (nrst),
    .ADDR           (addr),
    .WDATA          (wdata),
    .WR             (wr),
    .RD             (rd),
    .RDATA          (rdata),
    .LOWER_PIN_MODE (lower_mode),
    .PIN_IN         (pin_in),
    .PIN_OUT        (pin_out),
    .PIN_OE_N       (pin_oe_n)
  );

  // Free-running 25 MHz clock.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Case equality so that an unknown never passes as a match.
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check8

  // Expected enables and drive; drive is only meaningful where enabled.
  function automatic logic [15:0] exp_pins(input logic [7:0] up, input logic [7:0] lo, input logic [7:0] lvl);
    logic [15:0] modes;
    logic [7:0]  oe_n;
    logic [7:0]  drv;
    modes = {up, lo};
    oe_n  = 8'hFF;
    drv   = 8'h00;
    for (int k = 0; k < 8; k++) begin
      case (modes[2*k +: 2])
        ugcs_pkg::UGCS_MODE_OPEN_DRAIN: oe_n[k] = lvl[k];
        ugcs_pkg::UGCS_MODE_PUSH_PULL: begin
          oe_n[k] = 1'b0;
          drv[k]  = lvl[k];
        end
        default: oe_n[k] = 1'b1;
      endcase
    end
    return {oe_n, drv};
  endfunction : exp_pins

  // Called just after a rising edge; returns at the edge that took the write.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : write_reg

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    d = rdata;
    @(posedge clock);
  endtask : read_reg

  // Pins follow the registers one edge after the write is taken.
  task automatic check_pins;
    logic [15:0] e;
    @(posedge clock);
    @(negedge clock);
    e = exp_pins(mode_q, lower_mode, lvl_q);
    check8("pin enables", e[15:8], pin_oe_n);
    check8("pin drive", e[7:0], pin_out & ~e[15:8]);
    @(posedge clock);
  endtask : check_pins

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'hD8FC;
    mismatches = 0;
    checks = 0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    lower_mode = 8'h00;
    pin_in = 8'hA5;
    mode_q = 8'h00;
    lvl_q = 8'h00;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    // Reset state: open drain driven low, and reads show pins, not the level.
    check_pins;
    read_reg(8'h07, got);
    check8("upper mode after reset", 8'h00, got);
    read_reg(8'h01, got);
    check8("pin levels after reset", 8'hA5, got);
    $display("test reset done");
    // Every mode code on all upper pins at both levels.
    for (int m = 0; m < 4; m++) begin
      mode_q = {4{m[1:0]}};
      write_reg(8'h07, mode_q);
      read_reg(8'h07, got);
      check8("upper mode readback", mode_q, got);
      lvl_q = 8'hFF;
      write_reg(8'h01, lvl_q);
      check_pins;
      lvl_q = 8'h00;
      write_reg(8'h01, lvl_q);
      check_pins;
    end
    $display("test mode codes done");
    // Random mixes of per-pin modes, levels and pin inputs.
    for (int n = 0; n < 24; n++) begin
      mode_q = 8'($random(seed));
      lvl_q = 8'($random(seed));
      lower_mode <= 8'($random(seed));
      pin_in <= 8'($random(seed));
      write_reg(8'h07, mode_q);
      read_reg(8'h07, got);
      check8("upper mode readback", mode_q, got);
      write_reg(8'h01, lvl_q);
      check_pins;
      read_reg(8'h01, got);
      check8("pin levels", pin_in, got);
    end
    $display("test random done");
    // Writes to unmapped offsets leave both registers alone.
    write_reg(8'h02, 8'hFF);
    read_reg(8'h07, got);
    check8("upper mode after stray write", mode_q, got);
    write_reg(8'h06, 8'h55);
    check_pins;
    read_reg(8'h03, got);
    check8("unmapped read", ugcs_pkg::UNMAPPED_READ, got);
    $display("test unmapped done");
    // Second reset in mid-run brings both registers back to zero.
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    mode_q = 8'h00;
    lvl_q = 8'h00;
    read_reg(8'h07, got);
    check8("upper mode after second reset", 8'h00, got);
    check_pins;
    $display("test second reset done");
    report_and_stop();
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end

endmodule : testbench
